// [scb_chopper.sv]
// Chopper control for one bipolar bridge phase with a Wishbone register port.
`timescale 1ns/1ps
module scb_chopper
   import scb_pkg::*;
#(
   parameter int unsigned OSC_DIV   = CHOP_DIV,
   parameter int unsigned DEAD      = DEAD_CYCLES,
   parameter int unsigned SENSE     = SENSE_CYCLES,
   parameter int unsigned PBITS     = POS_BITS
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        step_clock,
   input  wire logic        direction_ccw,
   input  wire logic        motor_reset_n,
   input  wire logic        enable,
   input  wire logic        thermal_trip,
   input  wire logic        current_over,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             high_side_switch_a,
   output logic             high_side_switch_b,
   output logic             low_side_switch_a,
   output logic             low_side_switch_b,
   output logic             initial_state_monitor_out,
   output logic             initial_state_monitor_oe,
   output logic             protect_out,
   output logic             protect_oe
);
   localparam int unsigned OW = $clog2(OSC_DIV);
   localparam int unsigned SW = $clog2(SENSE + 1);
   localparam logic [OW-1:0] OSC_LAST   = OW'(OSC_DIV - 1);
   localparam logic [SW-1:0] SENSE_LOAD = SW'(SENSE);
   localparam logic [1:0]    CHOP_LAST  = 2'(CHOP_STEPS - 1);

   // Charge, slow and fast patterns for either current direction.
   function automatic logic [3:0] gate_decode(input scb_mode_e m, input logic rev);
      logic [3:0] g;
      g = GATES_OFF;
      case (m)
         SCB_CHARGE: g = rev ? 4'b0110 : 4'b1001;
         SCB_SLOW:   g = 4'b0011;
         SCB_FAST:   g = rev ? 4'b1001 : 4'b0110;
         default:    g = GATES_OFF;
      endcase
      return g;
   endfunction

   // Number of trailing chopping steps spent in fast decay.
   function automatic logic [2:0] fast_steps(input logic [1:0] setting);
      logic [2:0] n;
      n = 3'h0;
      case (setting)
         2'h0:    n = 3'h0;
         2'h1:    n = 3'h1;
         2'h2:    n = 3'h2;
         default: n = 3'h4;
      endcase
      return n;
   endfunction

   logic [1:0]       decay_setting;
   logic [OW-1:0]    osc_div;
   logic             osc_rise;
   logic [1:0]       chop_count;
   logic             step_d;
   logic             step_pending;
   logic             restart;
   logic             period_start;
   logic [SW-1:0]    sense_cnt;
   logic             reached;
   scb_mode_e        mode;
   scb_mode_e        next_mode;
   logic [PBITS-1:0] step_pos;
   logic [3:0]       gate_req;
   logic [3:0]       gates;
   logic             step_rise;
   logic             drive_ok;

   assign step_rise    = step_clock && !step_d;
   assign restart      = osc_rise && (step_pending || step_rise);
   assign period_start = osc_rise && (restart || chop_count == CHOP_LAST);
   assign drive_ok     = enable && !thermal_trip;

   // Internal chopping oscillator: one rising edge every OSC_DIV clocks.
   always_ff @(posedge mclk) begin
      if (reset) begin
         osc_div  <= '0;
         osc_rise <= 1'b0;
      end else begin
         osc_div  <= (osc_div == OSC_LAST) ? '0 : osc_div + 1'b1;
         osc_rise <= (osc_div == OSC_LAST);
      end
   end

   // A step arriving on the same edge as its service is still honoured.
   always_ff @(posedge mclk) begin
      if (reset) begin
         step_d       <= 1'b0;
         step_pending <= 1'b0;
      end else begin
         step_d       <= step_clock;
         step_pending <= (step_pending || step_rise) && !osc_rise;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         chop_count <= '0;
      end else if (period_start) begin
         chop_count <= '0;
      end else if (osc_rise) begin
         chop_count <= chop_count + 1'b1;
      end
   end

   // Each period opens with a short charge so the sense comparator sees real current.
   always_ff @(posedge mclk) begin
      if (reset) begin
         sense_cnt <= '0;
         reached   <= 1'b0;
      end else if (period_start) begin
         sense_cnt <= SENSE_LOAD;
         reached   <= 1'b0;
      end else begin
         if (sense_cnt != '0) begin
            sense_cnt <= sense_cnt - 1'b1;
         end
         if (sense_cnt == '0 && current_over) begin
            reached <= 1'b1;
         end
      end
   end

   always_comb begin
      next_mode = SCB_CHARGE;
      if (period_start || sense_cnt != '0) begin
         next_mode = SCB_CHARGE;
      end else if (reached || current_over) begin
         if ({1'b0, chop_count} >= 3'(CHOP_STEPS) - fast_steps(decay_setting)) begin
            next_mode = SCB_FAST;
         end else begin
            next_mode = SCB_SLOW;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         mode <= SCB_CHARGE;
      end else begin
         mode <= next_mode;
      end
   end

   // Position keeps following steps while disabled so re-enable resumes in place.
   always_ff @(posedge mclk) begin
      if (reset || !motor_reset_n) begin
         step_pos <= '0;
      end else if (step_rise) begin
         step_pos <= direction_ccw ? step_pos - 1'b1 : step_pos + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         gate_req <= GATES_OFF;
      end else begin
         gate_req <= drive_ok ? gate_decode(mode, step_pos[PBITS-1]) : GATES_OFF;
      end
   end

   scb_dead_time #(
      .DEAD (DEAD)
   ) u_dead (
      .mclk    (mclk),
      .reset   (reset),
      .request (gate_req),
      .gates   (gates)
   );

   assign high_side_switch_a = gates[G_HA];
   assign high_side_switch_b = gates[G_HB];
   assign low_side_switch_a  = gates[G_LA];
   assign low_side_switch_b  = gates[G_LB];

   // Open-drain status pins only ever pull low.
   always_ff @(posedge mclk) begin
      if (reset) begin
         initial_state_monitor_out <= 1'b0;
         initial_state_monitor_oe  <= 1'b0;
         protect_out               <= 1'b0;
         protect_oe                <= 1'b0;
      end else begin
         initial_state_monitor_out <= 1'b0;
         initial_state_monitor_oe  <= !motor_reset_n;
         protect_out               <= 1'b0;
         protect_oe                <= thermal_trip;
      end
   end

   // Single-cycle classic Wishbone slave; unmapped reads return zero.
   always_ff @(posedge mclk) begin
      if (reset) begin
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h0000_0000;
         decay_setting <= CTL_DECAY_RST;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= 32'h0000_0000;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            if (wb_we_i && wb_adr_i == ADDR_CONTROL && wb_sel_i[0]) begin
               decay_setting <= wb_dat_i[CTL_DECAY_LSB +: 2];
            end
            if (!wb_we_i && wb_adr_i == ADDR_CONTROL) begin
               wb_dat_o[CTL_DECAY_LSB +: 2] <= decay_setting;
            end
            if (!wb_we_i && wb_adr_i == ADDR_STATUS) begin
               wb_dat_o[ST_MODE_LSB +: 2]     <= mode;
               wb_dat_o[ST_TRIP_BIT]          <= thermal_trip;
               wb_dat_o[ST_INIT_BIT]          <= !motor_reset_n;
               wb_dat_o[ST_DRIVE_BIT]         <= gates != GATES_OFF;
               wb_dat_o[ST_CHOP_LSB +: 2]     <= chop_count;
               wb_dat_o[ST_POS_LSB +: PBITS]  <= step_pos;
            end
         end
      end
   end

   // Cycles since the first step edge that has not yet restarted the chopper.
   logic [OW:0] wait_cnt;
   always_ff @(posedge mclk) begin
      if (reset || restart || !(step_pending || step_rise)) begin
         wait_cnt <= '0;
      end else begin
         wait_cnt <= wait_cnt + 1'b1;
      end
   end

   restart_clear_a: assert property (@(posedge mclk) disable iff (reset)
      restart |=> chop_count == '0 && sense_cnt == SENSE_LOAD)
      else $error("Chopping counter not cleared on step restart.");
   restart_latency_a: assert property (@(posedge mclk) disable iff (reset)
      wait_cnt <= (OW+1)'(OSC_DIV))
      else $error("Step restart took longer than one oscillator period.");
   sense_charge_a: assert property (@(posedge mclk) disable iff (reset)
      restart |=> ##1 (mode == SCB_CHARGE) [*2])
      else $error("No charge sensing interval after step restart.");
   fwd_gates_a: assert property (@(posedge mclk) disable iff (reset)
      (drive_ok && !step_pos[PBITS-1] && mode == SCB_CHARGE) |=> gate_req == 4'b1001)
      else $error("Forward charge pattern wrong.");
   fwd_fast_a: assert property (@(posedge mclk) disable iff (reset)
      (drive_ok && !step_pos[PBITS-1] && mode == SCB_FAST) |=> gate_req == 4'b0110)
      else $error("Forward fast decay pattern wrong.");
   rev_charge_a: assert property (@(posedge mclk) disable iff (reset)
      (drive_ok && step_pos[PBITS-1] && mode == SCB_CHARGE) |=> gate_req == 4'b0110)
      else $error("Reverse charge pattern wrong.");
   slow_gates_a: assert property (@(posedge mclk) disable iff (reset)
      (drive_ok && mode == SCB_SLOW) |=> gate_req == 4'b0011)
      else $error("Slow decay pattern wrong.");
   rev_gates_a: assert property (@(posedge mclk) disable iff (reset)
      (drive_ok && step_pos[PBITS-1] && mode == SCB_FAST) |=> gate_req == 4'b1001)
      else $error("Reverse fast decay pattern wrong.");
   disable_off_a: assert property (@(posedge mclk) disable iff (reset)
      !enable [*3] |-> gates == GATES_OFF)
      else $error("Bridge driven while disabled.");
   step_count_a: assert property (@(posedge mclk) disable iff (reset)
      (motor_reset_n && step_rise && !direction_ccw) |=> step_pos == $past(step_pos) + 1'b1)
      else $error("Step position did not advance.");
   held_reset_a: assert property (@(posedge mclk) disable iff (reset)
      !motor_reset_n |=> step_pos == '0)
      else $error("Position moved while motor reset asserted.");
   trip_off_a: assert property (@(posedge mclk) disable iff (reset)
      thermal_trip [*3] |-> gates == GATES_OFF)
      else $error("Bridge driven during thermal trip.");
   pins_od_a: assert property (@(posedge mclk) disable iff (reset)
      !reset |=> ($past(!motor_reset_n) == initial_state_monitor_oe && $past(thermal_trip) == protect_oe))
      else $error("Open-drain status pin out of step.");
   wb_ack_a: assert property (@(posedge mclk) disable iff (reset)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("Wishbone ack not a single cycle.");

   restart_cov_c: cover property (@(posedge mclk) disable iff (reset) restart && mode == SCB_FAST);
   fast_cov_c: cover property (@(posedge mclk) disable iff (reset) mode == SCB_SLOW ##1 mode == SCB_FAST);
   resume_cov_c: cover property (@(posedge mclk) disable iff (reset) !enable && step_rise ##[1:50] enable);
endmodule

// [scb_pkg.sv]
// Shared constants and types for the stepper chopper bridge control block.
package scb_pkg;
   localparam int unsigned CLK_HZ       = 200_000_000;
   localparam int unsigned CHOP_HZ      = 100_000;
   localparam int unsigned CHOP_DIV     = CLK_HZ / CHOP_HZ;
   localparam int unsigned DEAD_NS      = 300;
   localparam int unsigned DEAD_CYCLES  = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned SENSE_NS     = 500;
   localparam int unsigned SENSE_CYCLES = (SENSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CHOP_STEPS   = 4;
   localparam int unsigned POS_BITS     = 4;

   // Wishbone register map, byte addresses.
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;

   // Control register fields and reset value.
   localparam int unsigned CTL_DECAY_LSB = 0;
   localparam logic [1:0]  CTL_DECAY_RST = 2'h0;

   // Status register field positions.
   localparam int unsigned ST_MODE_LSB  = 0;
   localparam int unsigned ST_TRIP_BIT  = 2;
   localparam int unsigned ST_INIT_BIT  = 3;
   localparam int unsigned ST_DRIVE_BIT = 4;
   localparam int unsigned ST_CHOP_LSB  = 8;
   localparam int unsigned ST_POS_LSB   = 16;

   // Gate vector bit positions: {high_a, high_b, low_a, low_b}.
   localparam int unsigned G_HA = 3;
   localparam int unsigned G_HB = 2;
   localparam int unsigned G_LA = 1;
   localparam int unsigned G_LB = 0;
   localparam logic [3:0]  GATES_OFF = 4'h0;

   typedef enum logic [1:0] {
      SCB_CHARGE = 2'b00,
      SCB_SLOW   = 2'b01,
      SCB_FAST   = 2'b11
   } scb_mode_e;
endpackage

// [scb_dead_time.sv]
// Bridge gate register with break-before-make dead time between drive patterns.
`timescale 1ns/1ps
module scb_dead_time
   import scb_pkg::*;
#(
   parameter int unsigned DEAD = DEAD_CYCLES
) (
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic [3:0] request,
   output logic      [3:0] gates
);
   localparam int unsigned CW = $clog2(DEAD + 1);
   localparam logic [CW-1:0] DEAD_LOAD = CW'(DEAD);

   logic [CW-1:0] dead_cnt;

   // Turning everything off is never delayed, so a trip or disable acts at once.
   always_ff @(posedge mclk) begin
      if (reset) begin
         gates    <= GATES_OFF;
         dead_cnt <= '0;
      end else if (request != gates) begin
         if (gates != GATES_OFF) begin
            gates    <= GATES_OFF;
            dead_cnt <= DEAD_LOAD;
         end else if (dead_cnt == '0) begin
            gates <= request;
         end else begin
            dead_cnt <= dead_cnt - 1'b1;
         end
      end else if (dead_cnt != '0) begin
         dead_cnt <= dead_cnt - 1'b1;
      end
   end

   // Starts full after reset, because no pattern was live before it.
   logic [CW-1:0] off_run;
   always_ff @(posedge mclk) begin
      if (reset) begin
         off_run <= DEAD_LOAD;
      end else if (gates != GATES_OFF) begin
         off_run <= '0;
      end else if (off_run != DEAD_LOAD) begin
         off_run <= off_run + 1'b1;
      end
   end

   dead_gap_a: assert property (@(posedge mclk) disable iff (reset)
      (gates != GATES_OFF && $past(gates) == GATES_OFF) |-> off_run == DEAD_LOAD)
      else $error("Bridge pattern changed without full dead time.");
   no_direct_a: assert property (@(posedge mclk) disable iff (reset)
      ($past(gates) != GATES_OFF && gates != GATES_OFF) |-> gates == $past(gates))
      else $error("Bridge switched between patterns without release.");
   dead_count_a: assert property (@(posedge mclk) disable iff (reset)
      ($past(gates) != GATES_OFF && gates == GATES_OFF && request != GATES_OFF && $stable(request))
      |-> ##[1:300] gates == request)
      else $error("Dead time did not end.");
   dead_cov_c: cover property (@(posedge mclk) disable iff (reset)
      $past(gates) != GATES_OFF && gates == GATES_OFF && request != GATES_OFF);
endmodule

// [scb_ctrl_model.sv]
// Behavioural motion controller that drives the step, reset and enable pins of the chopper.
`timescale 1ns/1ps
module scb_ctrl_model (
   input  wire logic supply_ok,
   input  wire logic mclk,
   input  wire logic want_run,
   input  wire logic want_enable,
   input  wire logic step_go,
   input  wire logic step_slow,
   output logic      step_clock,
   output logic      motor_reset_n,
   output logic      enable
);
   logic [3:0] step_cnt;

   // Pins stay low while supplies ramp; dropping the wishes first gives the reverse order at power-down.
   always_ff @(posedge mclk) begin
      motor_reset_n <= supply_ok & want_run;
      enable        <= supply_ok & want_enable;
   end

   // A step is a high pulse and a low gap, so edges are never closer than the chopper accepts.
   always_ff @(posedge mclk) begin
      if (!supply_ok) begin
         step_cnt   <= 4'h0;
         step_clock <= 1'b0;
      end else if (step_go && step_cnt == 4'h0) begin
         step_cnt   <= step_slow ? 4'hf : 4'h4;
         step_clock <= 1'b1;
      end else if (step_cnt != 4'h0) begin
         step_cnt   <= step_cnt - 4'h1;
         step_clock <= step_cnt > (step_slow ? 4'h8 : 4'h2);
      end
   end
endmodule

// [tb_stepper_chopper_bridge_control.sv]
// Self-checking bench for the chopper bridge control driven by a behavioural controller.
`timescale 1ns/1ps
module tb_stepper_chopper_bridge_control;
   import scb_pkg::*;
   localparam int unsigned OSC = 40;
   localparam int unsigned DT  = 4;
   localparam int unsigned SNS = 8;
   logic        mclk          = 1'b0;
   logic        reset         = 1'b1;
   logic        direction_ccw = 1'b0;
   logic        thermal_trip  = 1'b0;
   logic        current_over  = 1'b0;
   logic        supply_ok     = 1'b0;
   logic        want_run      = 1'b0;
   logic        want_enable   = 1'b0;
   logic        step_go       = 1'b0;
   logic        step_slow     = 1'b0;
   logic        wb_cyc_i      = 1'b0;
   logic        wb_stb_i      = 1'b0;
   logic        wb_we_i       = 1'b0;
   logic [7:0]  wb_adr_i      = 8'h00;
   logic [3:0]  wb_sel_i      = 4'h0;
   logic [31:0] wb_dat_i      = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic [31:0] rd;
   logic        wb_ack_o;
   logic        step_clock;
   logic        motor_reset_n;
   logic        enable;
   logic        ha;
   logic        hb;
   logic        la;
   logic        lb;
   logic        mon_out;
   logic        mon_oe;
   logic        prot_out;
   logic        prot_oe;
   logic [3:0]  gates;
   logic [3:0]  last_nz;
   logic [1:0]  dcy;
   int          zrun;
   int          n;
   int          err_total = 0;
   int          n_tests   = 0;

   assign gates = {ha, hb, la, lb};
   always #2.5 mclk = ~mclk;

   scb_ctrl_model ctrl (.supply_ok(supply_ok), .mclk(mclk), .want_run(want_run), .want_enable(want_enable),
      .step_go(step_go), .step_slow(step_slow), .step_clock(step_clock), .motor_reset_n(motor_reset_n),
      .enable(enable));

   scb_chopper #(.OSC_DIV(OSC), .DEAD(DT), .SENSE(SNS)) uut (.mclk(mclk), .reset(reset),
      .step_clock(step_clock), .direction_ccw(direction_ccw), .motor_reset_n(motor_reset_n),
      .enable(enable), .thermal_trip(thermal_trip), .current_over(current_over), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .high_side_switch_a(ha), .high_side_switch_b(hb),
      .low_side_switch_a(la), .low_side_switch_b(lb), .initial_state_monitor_out(mon_out),
      .initial_state_monitor_oe(mon_oe), .protect_out(prot_out), .protect_oe(prot_oe));

   // Expected gates {high_a, high_b, low_a, low_b} for mode 0 charge, 1 slow, 2 fast.
   function automatic logic [3:0] pat(input bit rev, input int m);
      if (m == 1) return 4'h3;
      if ((m == 0) != rev) return 4'h9;
      return 4'h6;
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input bit ok, input string msg);
      n_tests++;
      if (!ok) begin
         err_total++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
      int i;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      for (i = 0; i < 8 && wb_ack_o !== 1'b1; i++) @(posedge mclk);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge mclk);
      check(i < 8, "bus cycle not acknowledged");
      if (i >= 8) close_out();
   endtask

   task automatic step(input logic dir);
      direction_ccw <= dir;
      step_go       <= 1'b1;
      @(posedge mclk);
      step_go <= 1'b0;
      // A slow pulse keeps the controller busy for 16 cycles; an earlier request would be dropped.
      repeat (step_slow ? 16 : 8) @(posedge mclk);
   endtask

   task automatic wait_gates(input logic [3:0] exp, input int bound);
      int i;
      for (i = 0; i < bound && gates !== exp; i++) @(posedge mclk);
      check(i < bound, "gate pattern not reached");
      if (i == bound) close_out();
   endtask

   // Any swap between two live patterns must pass through an all-off gap.
   always @(posedge mclk) begin
      if (reset) begin
         last_nz = 4'h0;
         zrun    = 0;
      end else if (gates === 4'h0) begin
         zrun++;
      end else begin
         if (last_nz != 4'h0 && gates !== last_nz) check(zrun >= DT, "dead time too short");
         last_nz = gates;
         zrun    = 0;
      end
   end

   initial begin
      void'($urandom(74545));
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
      check(gates === 4'h0 && mon_oe === 1'b1 && mon_out === 1'b0, "idle pins after reset");
      wb(1'b0, ADDR_CONTROL, 32'h0000_0000, rd);
      check(rd[1:0] === CTL_DECAY_RST, "control reset value");
      dcy = 2'($urandom_range(3));
      wb(1'b1, ADDR_CONTROL, {30'h0, dcy}, rd);
      wb(1'b0, ADDR_CONTROL, 32'h0000_0000, rd);
      check(rd[1:0] === dcy, "control readback");
      wb(1'b0, 8'h08, 32'h0000_0000, rd);
      check(rd === 32'h0000_0000, "unmapped read not zero");
      wb(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
      check(rd[ST_INIT_BIT] === 1'b1 && rd[ST_DRIVE_BIT] === 1'b0, "status in initial state");
      $display("test registers done");
      supply_ok   <= 1'b1;
      want_enable <= 1'b1;
      wb(1'b1, ADDR_CONTROL, 32'h0000_0000, rd);
      repeat (3) step(1'b0);
      wb(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
      check(rd[ST_POS_LSB+:4] === 4'h0, "position moved while held");
      wait_gates(pat(0, 0), 200);
      $display("test held reset done");
      want_enable <= 1'b0;
      want_run    <= 1'b1;
      step_slow   <= 1'b1;
      repeat (4) @(posedge mclk);
      check(mon_oe === 1'b0, "monitor still low after release");
      n = 1 + $urandom_range(4);
      repeat (n) step(1'b0);
      check(gates === 4'h0, "bridge driven while disabled");
      wb(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
      check(rd[ST_POS_LSB+:4] === 4'(n), "position not advanced");
      step_slow   <= 1'b0;
      want_enable <= 1'b1;
      wait_gates(pat(0, 0), 200);
      $display("test enable gating done");
      for (int rev = 0; rev < 2; rev++) begin
         if (rev == 1) repeat (n + 2) step(1'b1);
         for (int m = 0; m < 3; m++) begin
            current_over <= (m != 0);
            wb(1'b1, ADDR_CONTROL, (m == 2) ? 32'h0000_0001 + 32'($urandom_range(1)) : 32'h0000_0000, rd);
            wait_gates(pat(rev[0], m), 400);
         end
         // Mixed decay above shows the slow-to-fast switch; the restart check wants fast decay throughout.
         wb(1'b1, ADDR_CONTROL, 32'h0000_0003, rd);
         // Step just after a periodic sense burst, so a charge seen now can only come from the restart.
         wait_gates(pat(rev[0], 0), 400);
         wait_gates(pat(rev[0], 2), 400);
         step(rev[0]);
         wait_gates(pat(rev[0], 0), OSC + DT + SNS + 4);
         $display("test bridge patterns direction %0d done", rev);
      end
      thermal_trip <= 1'b1;
      repeat (3) @(posedge mclk);
      check(gates === 4'h0 && prot_oe === 1'b1 && prot_out === 1'b0, "trip leaves bridge on");
      wb(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
      check(rd[ST_TRIP_BIT] === 1'b1, "trip not reported");
      thermal_trip <= 1'b0;
      wait_gates(pat(1, 2), 400);
      $display("test thermal trip done");
      want_enable <= 1'b0;
      repeat (4) @(posedge mclk);
      check(gates === 4'h0, "bridge on after enable drop");
      want_run <= 1'b0;
      @(posedge mclk);
      supply_ok <= 1'b0;
      repeat (3) @(posedge mclk);
      check(mon_oe === 1'b1, "monitor not low in initial state");
      $display("test power down done");
      close_out();
   end
endmodule
